/* hdl/twsr_params.svh */
// Constants shared by both ends of the two-wire register access link.
`ifndef TWSR_PARAMS_SVH
`define TWSR_PARAMS_SVH
`define TWSR_SADDR_HI 4'h8
`define TWSR_RW_WRITE 1'h0
`define TWSR_RW_READ 1'h1
`define TWSR_ACK_BIT 4'h8
`define TWSR_ADDR_BYTES 3'h3
`define TWSR_LAST_WBYTE 3'h6
`define TWSR_LAST_RBYTE 3'h3
`define TWSR_RESET_BYTE 8'hFF
`define TWSR_RELEASE_BYTE 8'hFF
`define TWSR_PIN_FUNC_RST 1'h1
`define TWSR_REF_HZ 25000000
`define TWSR_MAX_BPS 400000
`define TWSR_QTR_CYC ((`TWSR_REF_HZ + 4 * `TWSR_MAX_BPS - 1) / (4 * `TWSR_MAX_BPS))
`endif

/* hdl/twsr_pkg.sv */
// Types shared by both ends of the two-wire register access link.
`default_nettype none
package twsr_pkg;
  typedef enum logic [2:0] {
    TWSR_D_IDLE, TWSR_D_SADDR, TWSR_D_SACK, TWSR_D_RX, TWSR_D_RACK, TWSR_D_TX, TWSR_D_TACK
  } twsr_dev_st_t;
  typedef enum logic [1:0] {TWSR_H_IDLE, TWSR_H_START, TWSR_H_BIT, TWSR_H_STOP} twsr_host_st_t;
  typedef enum logic [1:0] {TWSR_K_WRITE, TWSR_K_READ, TWSR_K_BUSRST} twsr_kind_t;
endpackage
`default_nettype wire

/* hdl/twsr_link_if.sv */
// Open-drain two-wire link between the bus master end and the slave end.
`default_nettype none
interface twsr_link_if;
  logic scl_o_h;
  logic scl_oe_h;
  logic sda_o_h;
  logic sda_oe_h;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // Both lines are pulled up; any enabled driver with a low output pulls them down.
  assign scl = ~(scl_oe_h & ~scl_o_h);
  assign sda = ~((sda_oe_h & ~sda_o_h) | (sda_oe_d & ~sda_o_d));
  modport host (output scl_o_h, scl_oe_h, sda_o_h, sda_oe_h, input scl, sda);
  modport dev (output sda_o_d, sda_oe_d, input scl, sda);
endinterface
`default_nettype wire

/* hdl/twsr_host.sv */
// Bus master end: runs register writes, combined reads and bus reset sequences.
`default_nettype none
`include "twsr_params.svh"
module twsr_host
  import twsr_pkg::*;
#(
  parameter int QTR_CYC = `TWSR_QTR_CYC
) (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_cmd_valid, // Command request, taken when idle.
  input wire logic [1:0] i_cmd_kind, // 0 write, 1 read, 2 bus reset.
  input wire logic [2:0] i_cmd_slave, // Low three slave address bits.
  input wire logic [22:0] i_cmd_addr, // Channel, group and register number.
  input wire logic [31:0] i_cmd_wdata, // Write data.
  output logic o_busy, // Command in progress.
  output logic o_done, // One-cycle pulse when the STOP is complete.
  output logic o_nack, // Slave failed to acknowledge.
  output logic [31:0] o_rdata, // Data of the last read.
  twsr_link_if.host lnk // Two-wire link.
);
  ////////////////////////////////////////////////////////////////////////////
  twsr_host_st_t st_ff;
  twsr_kind_t kind_ff;
  logic [1:0] q_ff;
  logic [7:0] div_ff;
  logic [3:0] bit_ff;
  logic [3:0] byte_ff;
  logic [2:0] slv_ff;
  logic [22:0] addr_ff;
  logic [31:0] wd_ff;
  logic [31:0] rdata_ff;
  logic busy_ff, done_ff, nack_ff, ackbad_ff;
  logic scl_oe_ff, sda_oe_ff;
  logic sda_m_ff, sda_s_ff;
  logic [7:0] cur_byte;
  logic want_scl, want_sda;
  wire tick = busy_ff && (div_ff == 8'(QTR_CYC - 1));
  wire is_rd = (kind_ff == TWSR_K_READ);
  wire is_wr = (kind_ff == TWSR_K_WRITE);
  wire is_rst = (kind_ff == TWSR_K_BUSRST);
  wire rx_byte = is_rd && (byte_ff >= 4'h5);
  wire ack_slot = (bit_ff == `TWSR_ACK_BIT);
  wire bit_val = ack_slot ? (rx_byte ? (byte_ff == 4'h8) : 1'b1) : cur_byte[~bit_ff[2:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Byte on the wire for each position of the transfer.
  always_comb begin
    unique case (byte_ff)
      4'h0: cur_byte = is_rst ? `TWSR_RESET_BYTE : {`TWSR_SADDR_HI, slv_ff, `TWSR_RW_WRITE};
      4'h1: cur_byte = {1'b0, addr_ff[22:16]};
      4'h2: cur_byte = addr_ff[15:8];
      4'h3: cur_byte = addr_ff[7:0];
      4'h4: cur_byte = is_wr ? wd_ff[31:24] : {`TWSR_SADDR_HI, slv_ff, `TWSR_RW_READ};
      4'h5: cur_byte = is_wr ? wd_ff[23:16] : `TWSR_RELEASE_BYTE;
      4'h6: cur_byte = is_wr ? wd_ff[15:8] : `TWSR_RELEASE_BYTE;
      4'h7: cur_byte = is_wr ? wd_ff[7:0] : `TWSR_RELEASE_BYTE;
      default: cur_byte = `TWSR_RELEASE_BYTE;
    endcase
  end

  // Line levels for each quarter of each bus symbol.
  always_comb begin
    want_scl = 1'b1;
    want_sda = 1'b1;
    unique case (st_ff)
      TWSR_H_IDLE: begin
        want_scl = 1'b1;
        want_sda = 1'b1;
      end
      TWSR_H_START: begin
        want_scl = (q_ff == 2'h1) || (q_ff == 2'h2);
        want_sda = (q_ff < 2'h2);
      end
      TWSR_H_BIT: begin
        want_scl = (q_ff == 2'h1) || (q_ff == 2'h2);
        want_sda = bit_val;
      end
      TWSR_H_STOP: begin
        want_scl = (q_ff != 2'h0);
        want_sda = (q_ff >= 2'h2);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      div_ff <= 8'h00;
    end else begin
      sda_m_ff <= lnk.sda;
      sda_s_ff <= sda_m_ff;
      scl_oe_ff <= ~want_scl;
      sda_oe_ff <= ~want_sda;
      div_ff <= (tick || !busy_ff) ? 8'h00 : div_ff + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= TWSR_H_IDLE;
      kind_ff <= TWSR_K_WRITE;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 4'h0;
      slv_ff <= 3'h0;
      addr_ff <= 23'h000000;
      wd_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      ackbad_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (st_ff == TWSR_H_IDLE) begin
        if (i_cmd_valid) begin
          kind_ff <= twsr_kind_t'(i_cmd_kind);
          slv_ff <= i_cmd_slave;
          addr_ff <= i_cmd_addr;
          wd_ff <= i_cmd_wdata;
          busy_ff <= 1'b1;
          nack_ff <= 1'b0;
          st_ff <= TWSR_H_START;
          q_ff <= 2'h0;
          bit_ff <= 4'h0;
          byte_ff <= 4'h0;
        end
      end else if (tick) begin
        q_ff <= q_ff + 2'h1;
        if (q_ff == 2'h2 && st_ff == TWSR_H_BIT) begin
          if (!ack_slot && rx_byte) begin
            rdata_ff <= {rdata_ff[30:0], sda_s_ff};
          end
          ackbad_ff <= sda_s_ff;
        end
        if (q_ff == 2'h3) begin
          unique case (st_ff)
            TWSR_H_START: begin
              bit_ff <= 4'h0;
              st_ff <= (is_rst && byte_ff != 4'h0) ? TWSR_H_STOP : TWSR_H_BIT;
            end
            TWSR_H_BIT: begin
              if (!ack_slot) begin
                bit_ff <= bit_ff + 4'h1;
              end else begin
                bit_ff <= 4'h0;
                byte_ff <= byte_ff + 4'h1;
                if (is_rst) begin
                  st_ff <= TWSR_H_START;
                end else if (!rx_byte && ackbad_ff) begin
                  nack_ff <= 1'b1;
                  st_ff <= TWSR_H_STOP;
                end else if (is_rd && byte_ff == 4'h3) begin
                  st_ff <= TWSR_H_START;
                end else if ((is_rd && byte_ff == 4'h8) || (!is_rd && byte_ff == 4'h7)) begin
                  st_ff <= TWSR_H_STOP;
                end
              end
            end
            TWSR_H_STOP: begin
              st_ff <= TWSR_H_IDLE;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end
            default: st_ff <= TWSR_H_IDLE;
          endcase
        end
      end
    end
  end

  assign lnk.scl_o_h = 1'b0;
  assign lnk.sda_o_h = 1'b0;
  assign lnk.scl_oe_h = scl_oe_ff;
  assign lnk.sda_oe_h = sda_oe_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_nack = nack_ff;
  assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

/* hdl/twsr_dev.sv */
// Slave end: decodes two-wire transfers and turns them into register requests.
// Contract
// - Pins serve clock and data after reset
// - Slave address is 1000 plus three pins
// - Master clocks at most 400 kbps
// - Master uses seven-bit slave addressing only
// - Transfer begins with START condition
// - Bytes travel most significant bit first
// - Data changes only while clock low
// - Receiver acknowledges each byte by pulling low
// - Transfer ends with STOP condition
// - START, nine high clocks, START, STOP resets
// - Master issues bus reset after losing sync (the host sends one only when given a bus reset command)
// - Address: zero, channel, group, register number
// - Invalid address reads return zero
// - Four data bytes, high byte first
// - Undefined register bits read as zero
// - Write: address, three address bytes, four data
// - Read: address write, repeated START, read
// - Master ends read with no acknowledge
// - Sequential reads and writes are served
`default_nettype none
`include "twsr_params.svh"
module twsr_dev
  import twsr_pkg::*;
(
  input wire logic i_ref_clk, // Device clock for the register side.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_link_clk, // Sampling clock of the link side.
  input wire logic i_port_addr_pin_four, // Port address pin four.
  input wire logic i_port_addr_pin_three, // Port address pin three.
  input wire logic i_port_addr_pin_two, // Port address pin two.
  output logic o_pins_i2c_sel, // Multifunction pins serve the link.
  output logic o_req, // One-cycle register access pulse.
  output logic o_we, // Access is a write.
  output logic [22:0] o_addr, // Channel, group and register number.
  output logic [31:0] o_wdata, // Write data.
  input wire logic i_ack, // Register side finished the access.
  input wire logic [31:0] i_rdata, // Read data, valid with i_ack.
  input wire logic i_addr_ok, // Addressed register exists, valid with i_ack.
  twsr_link_if.dev lnk // Two-wire link.
);
  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the link sampling clock.
  logic [1:0] lrst_ff;
  logic scl_m_ff, scl_s_ff, scl_q_ff;
  logic sda_m_ff, sda_s_ff, sda_q_ff;
  logic [2:0] pa_m_ff, pa_s_ff;
  twsr_dev_st_t st_ff;
  logic [3:0] bit_ff;
  logic [2:0] byte_ff;
  logic [7:0] sh_ff;
  logic rw_ff;
  logic [23:0] addr_ff;
  logic [23:0] wd_ff;
  logic [31:0] tx_ff;
  logic sda_oe_ff;
  logic mack_ff;
  logic req_tgl_ff;
  logic lwe_ff;
  logic lbad_ff;
  logic [23:0] lad_ff;
  logic [31:0] lwd_ff;
  logic ak_m_ff, ak_s_ff, ak_q_ff;
  logic [31:0] rd_ff;
  // Register side, clocked by the device clock.
  logic rq_m_ff, rq_s_ff, rq_q_ff;
  logic wait_ff;
  logic ack_tgl_ff;
  logic [31:0] rdat_ff;
  logic req_ff, we_ff, sel_ff;
  logic [22:0] oaddr_ff;
  logic [31:0] owd_ff;

  wire lrst = lrst_ff[1];
  wire scl_rise = scl_s_ff & ~scl_q_ff;
  wire scl_fall = ~scl_s_ff & scl_q_ff;
  wire start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  wire stop_det = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  wire [6:0] my_addr = {`TWSR_SADDR_HI, pa_s_ff};
  wire addr_hit = (sh_ff[7:1] == my_addr);
  wire byte_done = scl_fall && (bit_ff == `TWSR_ACK_BIT);
  wire is_addr_byte = (byte_ff < `TWSR_ADDR_BYTES);
  wire last_wbyte = (byte_ff == `TWSR_LAST_WBYTE);
  wire last_rbyte = (byte_ff == `TWSR_LAST_RBYTE);
  wire [31:0] wword = {wd_ff, sh_ff};
  wire [15:0] reg_next = addr_ff[15:0] + 16'h0001;
  wire ack_evt = ak_s_ff ^ ak_q_ff;
  wire rd_fetch = scl_rise && ((st_ff == TWSR_D_SACK && rw_ff) ||
                  (st_ff == TWSR_D_TACK && !sda_s_ff && last_rbyte));
  wire wr_issue = byte_done && st_ff == TWSR_D_RX && last_wbyte && !addr_ff[23];
  wire req_evt = rq_s_ff ^ rq_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers of the link side.
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      lrst_ff <= 2'h3;
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      pa_m_ff <= 3'h0;
      pa_s_ff <= 3'h0;
      ak_m_ff <= 1'b0;
      ak_s_ff <= 1'b0;
      ak_q_ff <= 1'b0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b0};
      scl_m_ff <= lnk.scl;
      scl_s_ff <= scl_m_ff;
      scl_q_ff <= scl_s_ff;
      sda_m_ff <= lnk.sda;
      sda_s_ff <= sda_m_ff;
      sda_q_ff <= sda_s_ff;
      pa_m_ff <= {i_port_addr_pin_four, i_port_addr_pin_three, i_port_addr_pin_two};
      pa_s_ff <= pa_m_ff;
      ak_m_ff <= ack_tgl_ff;
      ak_s_ff <= ak_m_ff;
      ak_q_ff <= ak_s_ff;
    end
  end

  // Requests toward the register side; fields hold until the next request.
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      req_tgl_ff <= 1'b0;
      lwe_ff <= 1'b0;
      lbad_ff <= 1'b0;
      lad_ff <= 24'h000000;
      lwd_ff <= 32'h00000000;
      rd_ff <= 32'h00000000;
    end else begin
      if (ack_evt) begin
        rd_ff <= rdat_ff;
      end
      if (wr_issue) begin
        req_tgl_ff <= ~req_tgl_ff;
        lwe_ff <= 1'b1;
        lbad_ff <= 1'b0;
        lad_ff <= addr_ff;
        lwd_ff <= wword;
      end else if (rd_fetch) begin
        req_tgl_ff <= ~req_tgl_ff;
        lwe_ff <= 1'b0;
        lbad_ff <= addr_ff[23];
        lad_ff <= (st_ff == TWSR_D_TACK) ? {addr_ff[23:16], reg_next} : addr_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine.
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= TWSR_D_IDLE;
      bit_ff <= 4'h0;
      byte_ff <= 3'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 24'h000000;
      wd_ff <= 24'h000000;
      tx_ff <= 32'h00000000;
      sda_oe_ff <= 1'b0;
      mack_ff <= 1'b0;
    end else if (lrst || start_det) begin
      st_ff <= lrst ? TWSR_D_IDLE : TWSR_D_SADDR;
      bit_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      st_ff <= TWSR_D_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        TWSR_D_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        TWSR_D_SADDR, TWSR_D_RX: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s_ff};
            bit_ff <= bit_ff + 4'h1;
          end
          if (byte_done && st_ff == TWSR_D_SADDR) begin
            if (addr_hit) begin
              rw_ff <= sh_ff[0];
              sda_oe_ff <= 1'b1;
              st_ff <= TWSR_D_SACK;
            end else begin
              st_ff <= TWSR_D_IDLE;
            end
          end else if (byte_done) begin
            sda_oe_ff <= 1'b1;
            st_ff <= TWSR_D_RACK;
            byte_ff <= last_wbyte ? `TWSR_ADDR_BYTES : byte_ff + 3'h1;
            if (is_addr_byte) begin
              addr_ff <= {addr_ff[15:0], sh_ff};
            end else begin
              wd_ff <= wword[23:0];
            end
            if (last_wbyte) begin
              addr_ff[15:0] <= reg_next;
            end
          end
        end
        TWSR_D_SACK: begin
          if (scl_fall) begin
            bit_ff <= 4'h0;
            byte_ff <= 3'h0;
            if (rw_ff) begin
              sda_oe_ff <= ~rd_ff[31];
              tx_ff <= {rd_ff[30:0], 1'b0};
              st_ff <= TWSR_D_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              st_ff <= TWSR_D_RX;
            end
          end
        end
        TWSR_D_RACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            bit_ff <= 4'h0;
            st_ff <= TWSR_D_RX;
          end
        end
        TWSR_D_TX: begin
          if (scl_rise) begin
            bit_ff <= bit_ff + 4'h1;
          end
          if (byte_done) begin
            sda_oe_ff <= 1'b0;
            st_ff <= TWSR_D_TACK;
          end else if (scl_fall) begin
            sda_oe_ff <= ~tx_ff[31];
            tx_ff <= {tx_ff[30:0], 1'b0};
          end
        end
        TWSR_D_TACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s_ff;
            if (!sda_s_ff && last_rbyte) begin
              addr_ff[15:0] <= reg_next;
            end
          end
          if (scl_fall) begin
            bit_ff <= 4'h0;
            if (!mack_ff) begin
              st_ff <= TWSR_D_IDLE;
            end else begin
              st_ff <= TWSR_D_TX;
              byte_ff <= last_rbyte ? 3'h0 : byte_ff + 3'h1;
              sda_oe_ff <= last_rbyte ? ~rd_ff[31] : ~tx_ff[31];
              tx_ff <= last_rbyte ? {rd_ff[30:0], 1'b0} : {tx_ff[30:0], 1'b0};
            end
          end
        end
        default: st_ff <= TWSR_D_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register side: takes each request across and returns the answer.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rq_m_ff <= 1'b0;
      rq_s_ff <= 1'b0;
      rq_q_ff <= 1'b0;
      wait_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      oaddr_ff <= 23'h000000;
      owd_ff <= 32'h00000000;
      sel_ff <= `TWSR_PIN_FUNC_RST;
    end else begin
      rq_m_ff <= req_tgl_ff;
      rq_s_ff <= rq_m_ff;
      rq_q_ff <= rq_s_ff;
      req_ff <= 1'b0;
      if (req_evt) begin
        we_ff <= lwe_ff;
        oaddr_ff <= lad_ff[22:0];
        owd_ff <= lwd_ff;
        if (lbad_ff) begin
          rdat_ff <= 32'h00000000;
          ack_tgl_ff <= ~ack_tgl_ff;
        end else begin
          req_ff <= 1'b1;
          wait_ff <= 1'b1;
        end
      end else if (wait_ff && i_ack) begin
        rdat_ff <= i_addr_ok ? i_rdata : 32'h00000000;
        ack_tgl_ff <= ~ack_tgl_ff;
        wait_ff <= 1'b0;
      end
    end
  end

  assign lnk.sda_o_d = 1'b0;
  assign lnk.sda_oe_d = sda_oe_ff;
  assign o_pins_i2c_sel = sel_ff;
  assign o_req = req_ff;
  assign o_we = we_ff;
  assign o_addr = oaddr_ff;
  assign o_wdata = owd_ff;
endmodule
`default_nettype wire

/* testbench/twsr_chk.sv */
// Checker for the wire-level behaviour of the two-wire register access link.
`default_nettype none
module twsr_chk (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic i_link_clk, // Link sampling clock.
  input wire logic i_rst, // Reset, active high.
  input wire logic i_port_addr_pin_four, // Slave address bit 2.
  input wire logic i_port_addr_pin_three, // Slave address bit 1.
  input wire logic i_port_addr_pin_two, // Slave address bit 0.
  input wire logic scl_o_h, // Host clock output.
  input wire logic scl_oe_h, // Host clock enable.
  input wire logic sda_o_d, // Device data output.
  input wire logic sda_oe_d, // Device data enable.
  input wire logic scl, // Resolved clock line.
  input wire logic sda // Resolved data line.
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  logic scl_q_ff, sda_q_ff, first_ff;
  logic [3:0] cnt_ff;
  logic [7:0] byte_ff;
  wire logic start_w = scl & scl_q_ff & sda_q_ff & ~sda;
  wire logic rise_w = scl & ~scl_q_ff;
  wire logic ninth_w = rise_w & (cnt_ff == 4'h8);
  wire logic [2:0] pins_w = {i_port_addr_pin_four, i_port_addr_pin_three, i_port_addr_pin_two};
  wire logic match_w = byte_ff[7:1] == {4'h8, pins_w};
  wire logic [3:0] nxt_cnt = start_w | ninth_w ? 4'h0 : cnt_ff + {3'h0, rise_w};
  wire logic nxt_first = start_w | (first_ff & ~ninth_w);
  wire logic [7:0] nxt_byte = rise_w & ~ninth_w ? {byte_ff[6:0], sda} : byte_ff;
  // Counts clock pulses since the last START or ninth pulse so the address acknowledge slot is known.
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      {scl_q_ff, sda_q_ff, first_ff, cnt_ff, byte_ff} <= 15'h6000;
    end else begin
      {scl_q_ff, sda_q_ff, first_ff, cnt_ff, byte_ff} <= {scl, sda, nxt_first, nxt_cnt, nxt_byte};
    end
  end
  ////////////////////////////////////////////////////////////
  sequence start_seq;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence stop_seq;
    $rose(sda) && scl && $past(scl);
  endsequence
  start_released_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    start_seq |-> !sda_oe_d) else $error("device pulled data low during a start");
  stop_release_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    stop_seq |=> !sda_oe_d [*8]) else $error("device drove data after a stop");
  dev_hold_high_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    scl && $past(scl) |-> $stable(sda_oe_d)) else $error("device data changed while clock high");
  drive_low_only_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    !(sda_oe_d && sda_o_d) && !(scl_oe_h && scl_o_h)) else $error("line driven high");
  addr_ack_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    ninth_w && first_ff |-> sda_oe_d == match_w) else $error("address acknowledge wrong");
  scl_high_min_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(scl_oe_h) |=> !scl_oe_h [*8]) else $error("clock high phase too short");
  scl_low_min_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(scl_oe_h) |=> scl_oe_h [*8]) else $error("clock low phase too short");
  ack_clock_low_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $changed(sda_oe_d) |-> !scl) else $error("device data moved outside clock low");
endmodule
`default_nettype wire

/* testbench/two_wire_slave_register_access_test.sv */
// Testbench joining the host end and the slave end over the two-wire link.
`default_nettype none
module two_wire_slave_register_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, ex, got) \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      miscompares++; \
    end
  logic i_ref_clk, i_link_clk, i_rst, i_cmd_valid, i_ack, i_addr_ok;
  logic o_busy, o_done, o_nack, o_pins_i2c_sel, o_req, o_we;
  logic [1:0] i_cmd_kind;
  logic [2:0] i_cmd_slave, pins;
  logic [22:0] i_cmd_addr, o_addr, a;
  logic [31:0] i_cmd_wdata, i_rdata, o_rdata, o_wdata, dt;
  logic [55:0] exp_req[$];
  logic [34:0] exp_done[$];
  logic [31:0] mem[logic [22:0]];
  int seed = 73;
  int miscompares = 0;
  int samples_checked = 0;
  twsr_link_if lnk ();
  twsr_host i_twsr_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind), .i_cmd_slave(i_cmd_slave),
    .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_nack(o_nack), .o_rdata(o_rdata), .lnk(lnk));
  twsr_dev i_twsr_dev (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_port_addr_pin_four(pins[2]), .i_port_addr_pin_three(pins[1]),
    .i_port_addr_pin_two(pins[0]), .o_pins_i2c_sel(o_pins_i2c_sel), .o_req(o_req),
    .o_we(o_we), .o_addr(o_addr), .o_wdata(o_wdata), .i_ack(i_ack), .i_rdata(i_rdata),
    .i_addr_ok(i_addr_ok), .lnk(lnk));
  twsr_chk i_twsr_chk (.i_ref_clk(i_ref_clk), .i_link_clk(i_link_clk), .i_rst(i_rst),
    .i_port_addr_pin_four(pins[2]), .i_port_addr_pin_three(pins[1]),
    .i_port_addr_pin_two(pins[0]), .scl_o_h(lnk.scl_o_h), .scl_oe_h(lnk.scl_oe_h),
    .sda_o_d(lnk.sda_o_d), .sda_oe_d(lnk.sda_oe_d), .scl(lnk.scl), .sda(lnk.sda));
  ////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #7;
    forever #32 i_link_clk = ~i_link_clk;
  end
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Register side: answers each access after a random delay and keeps written words.
  // Channels two and three hold no registers here, so they read as invalid.
  initial begin : resp
    int lat;
    forever begin
      @(negedge i_ref_clk);
      if (o_req === 1'b1) begin
        lat = 1 + ($unsigned($random(seed)) % 3);
        repeat (lat) @(posedge i_ref_clk);
        i_addr_ok <= mem.exists(o_addr) && !o_addr[22];
        i_rdata <= mem.exists(o_addr) ? mem[o_addr] : $random(seed);
        if (o_we && !o_addr[22]) mem[o_addr] = o_wdata;
        i_ack <= 1'b1;
        @(posedge i_ref_clk);
        i_ack <= 1'b0;
      end
    end
  end
  // Oldest note is taken off each queue whenever the matching result appears.
  always @(negedge i_ref_clk) begin : mon
    logic [55:0] e;
    logic [34:0] d;
    if (o_req === 1'b1) begin
      e = exp_req.size() ? exp_req.pop_front() : 'x;
      `CHK("access_we_addr", e[55:32], {o_we, o_addr})
      if (e[55]) begin
        `CHK("access_wdata", e[31:0], o_wdata)
      end
    end
    if (o_done === 1'b1) begin
      d = exp_done.size() ? exp_done.pop_front() : 'x;
      if (d[34:33] !== 2'h0) begin
        `CHK("host_nack", d[32], o_nack)
      end
      if (d[34]) begin
        `CHK("host_rdata", d[31:0], o_rdata)
      end
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic cmd(input logic [1:0] k, input logic [2:0] s, input logic [22:0] ad,
    input logic [31:0] wd, input logic [34:0] ex);
    int n;
    exp_done.push_back(ex);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_kind <= k;
    i_cmd_slave <= s;
    i_cmd_addr <= ad;
    i_cmd_wdata <= wd;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
      if (n == 1) begin
        `CHK("host_busy", 1'b1, o_busy)
      end
    end while (o_done !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [22:0] ad, input logic [31:0] wd,
    input logic nk);
    if (!nk) exp_req.push_back({1'b1, ad, wd});
    cmd(2'h0, s, ad, wd, {2'h1, nk, 32'h0});
  endtask
  task automatic rd(input logic [2:0] s, input logic [22:0] ad, input logic [31:0] ex);
    exp_req.push_back({1'b0, ad, 32'h0});
    cmd(2'h1, s, ad, 32'h0, {2'h3, 1'b0, ex});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {i_cmd_valid, i_ack, i_addr_ok, i_cmd_kind, i_cmd_slave} = 8'h00;
    {i_cmd_addr, i_cmd_wdata, i_rdata} = 87'h0;
    pins = 3'($random(seed));
    i_rst = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    `CHK("pin_function", 1'b1, o_pins_i2c_sel)
    // Pin patterns 0, 5, 2, 7 give every address pin both levels.
    for (int i = 0; i < 4; i++) begin
      @(posedge i_ref_clk);
      pins <= 3'(i * 5);
      repeat (4) @(posedge i_ref_clk);
      a = 23'($random(seed)) & 23'h3FFFFF;
      dt = $random(seed);
      wr(3'(i * 5), a, dt, 1'b0);
      rd(3'(i * 5), a, dt);
      wr(3'(i * 5) ^ 3'h1, a, ~dt, 1'b1);
    end
    rd(pins, a ^ 23'h00FFFF, mem.exists(a ^ 23'h00FFFF) ? mem[a ^ 23'h00FFFF] : 32'h0);
    wr(pins, a | 23'h400000, ~dt, 1'b0);
    rd(pins, a | 23'h400000, 32'h0);
    cmd(2'h2, pins, 23'h0, 32'h0, 35'h0);
    wr(pins, a, ~dt, 1'b0);
    rd(pins, a, ~dt);
    final_report();
  end
endmodule
`default_nettype wire
